// File: kq_pkg.sv
package kq_pkg;
   localparam int KQ_DEPTH = 16;
   localparam int KQ_PTR_W = 4;
   localparam int KQ_CNT_W = 5;
   localparam logic [KQ_CNT_W-1:0] KQ_CNT_FULL = 5'h10;
   localparam logic [KQ_CNT_W-1:0] KQ_CNT_ONE = 5'h01;
   localparam logic [KQ_CNT_W-1:0] KQ_CNT_ZERO = 5'h00;
   localparam logic [7:0] KQ_QUEUE_ADDR = 8'h00;
   localparam logic [7:0] KQ_UNMAPPED_DATA = 8'h00;
   localparam logic [3:0] KQ_SLAVE_PREFIX = 4'h7;
   localparam logic [5:0] KQ_KEY_STATUS = 6'h3F;
   localparam logic [5:0] KQ_KEY_REPEAT = 6'h3E;
   localparam logic [5:0] KQ_KEY_FIRST_SPECIAL = 6'h3E;
   localparam logic [7:0] KQ_CODE_EMPTY = 8'h3F;
   localparam logic [7:0] KQ_CODE_OVERFLOW = 8'h7F;
   localparam int KQ_BIT_MORE = 7;
   localparam int KQ_BIT_RELEASE = 6;
   localparam int KQ_ENTRY_REPEAT = 7;
   localparam int KQ_ENTRY_RELEASE = 6;
   localparam logic [3:0] KQ_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] KQ_BIT_CNT_ZERO = 4'h0;
   localparam logic [3:0] KQ_BIT_CNT_ONE = 4'h1;
   localparam logic [7:0] KQ_PTR_STEP = 8'h01;
   localparam logic [KQ_PTR_W-1:0] KQ_IDX_ONE = 4'h1;

   typedef enum logic [6:0] {
      KQ_IDLE = 7'h01,
      KQ_ADDR = 7'h02,
      KQ_ADDR_ACK = 7'h04,
      KQ_WR_BYTE = 7'h08,
      KQ_WR_ACK = 7'h10,
      KQ_RD_BYTE = 7'h20,
      KQ_RD_ACK = 7'h40
   } kq_state_t;
endpackage

// File: kq_evt_cdc.sv
module kq_evt_cdc
   import kq_pkg::*;
(
   input wire logic scan_clk,
   input wire logic clk,
   input wire logic resetn,
   input wire logic src_valid,
   input wire logic [7:0] src_data,
   output logic src_ready,
   output logic dst_pulse,
   output logic [7:0] dst_data
);
   ////////////////////////////////////////////////////////////////////////////
   // Scan side: toggle request, data held until acknowledged
   logic req_reg, req_next;
   logic [7:0] hold_reg, hold_next;
   logic ready_reg, ready_next;
   logic ack_s1_reg, ack_s2_reg;
   logic ack_reg, ack_next;
   logic req_s1_reg, req_s2_reg;
   logic pulse_reg, pulse_next;
   logic [7:0] data_reg, data_next;

   always_comb begin
      req_next = req_reg;
      hold_next = hold_reg;
      if (src_valid && ready_reg) begin
         req_next = ~req_reg;
         hold_next = src_data;
      end
      // Conservative: ready may lag the ack by a cycle, never leads it
      ready_next = (req_next == ack_s2_reg);
   end

   always_ff @(posedge scan_clk or negedge resetn) begin
      if (!resetn) begin
         req_reg <= 1'b0;
         hold_reg <= 8'h00;
         ready_reg <= 1'b0;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end else begin
         req_reg <= req_next;
         hold_reg <= hold_next;
         ready_reg <= ready_next;
         ack_s1_reg <= ack_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core side: hold_reg is stable whenever the synced request differs
   always_comb begin
      ack_next = ack_reg;
      pulse_next = 1'b0;
      data_next = data_reg;
      if (req_s2_reg != ack_reg) begin
         ack_next = req_s2_reg;
         pulse_next = 1'b1;
         data_next = hold_reg;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         ack_reg <= 1'b0;
         pulse_reg <= 1'b0;
         data_reg <= 8'h00;
      end else begin
         req_s1_reg <= req_reg;
         req_s2_reg <= req_s1_reg;
         ack_reg <= ack_next;
         pulse_reg <= pulse_next;
         data_reg <= data_next;
      end
   end

   assign src_ready = ready_reg;
   assign dst_pulse = pulse_reg;
   assign dst_data = data_reg;
endmodule

// File: kq_key_event_queue.sv
// What this block does
// R1 - Every byte read from the event register carries the reported key number in its six low bits.
// R2 - For ordinary keys the top bit is clear on the last queued event and set when more remain.
// R3 - Outside autorepeat entries, bit six is set for a key release and clear for a keypress.
// R4 - Outside autorepeat entries, keys 62 and 63 read with the top bit set, and an empty queue reads 0x3F.
// R5 - After an overflow one read returns 0x7F and the queued data stays readable after it.
// R6 - An autorepeat that is the last entry reads as 0x3E.
// R7 - An autorepeat with more entries behind it reads as 0x7E.
// R8 - After a key 62 or 63 event the host reads once more to learn whether more events wait.
// R9 - The event queue is an eight-bit read location at register address zero.
// R10 - The stored command byte is the read pointer, set by a write and followed by burst reads.
// R11 - With the clear-mode input low the alert is released once the queue is empty.
// R12 - The queue holds sixteen events, each read except the 0x7F overflow report pops the oldest, and the pointer stays at zero.
module kq_key_event_queue
   import kq_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic scan_clk,
   input wire logic evt_valid,
   input wire logic [5:0] evt_key,
   input wire logic evt_release,
   input wire logic evt_repeat,
   output logic evt_ready,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [2:0] addr_sel,
   input wire logic int_clr_cfg,
   output logic key_alert_n
);
   function automatic logic [7:0] kq_next_ptr(input logic [7:0] p);
      // Queue address never advances so bursts keep draining events
      kq_next_ptr = (p == KQ_QUEUE_ADDR) ? KQ_QUEUE_ADDR : p + KQ_PTR_STEP; // R12
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Event crossing from the scan clock
   logic push;
   logic [7:0] push_data;

   kq_evt_cdc u_cdc (
      .scan_clk(scan_clk),
      .clk(clk),
      .resetn(resetn),
      .src_valid(evt_valid),
      .src_data({evt_repeat, evt_release, evt_key}),
      .src_ready(evt_ready),
      .dst_pulse(push),
      .dst_data(push_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic sda_s1_reg, sda_s2_reg, sda_d_reg;
   logic [2:0] sel_s1_reg, sel_s2_reg;
   logic cfg_s1_reg, cfg_s2_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         sel_s1_reg <= 3'h0;
         sel_s2_reg <= 3'h0;
         cfg_s1_reg <= 1'b0;
         cfg_s2_reg <= 1'b0;
      end else begin
         scl_s1_reg <= scl_in;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg <= scl_s2_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg <= sda_s2_reg;
         sel_s1_reg <= addr_sel;
         sel_s2_reg <= sel_s1_reg;
         cfg_s1_reg <= int_clr_cfg;
         cfg_s2_reg <= cfg_s1_reg;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl_s2_reg & ~scl_d_reg;
   assign scl_fall = ~scl_s2_reg & scl_d_reg;
   assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign bus_stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Event queue
   logic [7:0] mem_reg [KQ_DEPTH];
   logic [7:0] mem_next [KQ_DEPTH];
   logic [KQ_PTR_W-1:0] wr_idx_reg, wr_idx_next, rd_idx_reg, rd_idx_next;
   logic [KQ_CNT_W-1:0] count_reg, count_next;
   logic ovf_reg, ovf_next;
   logic alert_n_reg, alert_n_next;
   logic pop, ovf_report;
   logic [7:0] head, head_code;
   logic more;

   // Head entry encoding
   always_comb begin
      head = mem_reg[rd_idx_reg];
      more = (count_reg > KQ_CNT_ONE);
      if (head[KQ_ENTRY_REPEAT]) begin
         head_code = {1'b0, more, KQ_KEY_REPEAT}; // R6 R7
      end else if (head[5:0] >= KQ_KEY_FIRST_SPECIAL) begin
         // More-data state is hidden here, host reads once more
         head_code = {1'b1, head[KQ_ENTRY_RELEASE], head[5:0]}; // R4 R8
      end else begin
         head_code = {more, head[KQ_ENTRY_RELEASE], head[5:0]}; // R1 R2 R3
      end
   end

   always_comb begin
      mem_next = mem_reg;
      wr_idx_next = wr_idx_reg;
      rd_idx_next = rd_idx_reg;
      count_next = count_reg;
      ovf_next = ovf_reg;
      if (ovf_report) begin
         ovf_next = 1'b0; // R5
      end
      if (pop) begin
         rd_idx_next = rd_idx_reg + KQ_IDX_ONE; // R12
         count_next = count_reg - KQ_CNT_ONE;
      end
      if (push) begin
         if (count_reg == KQ_CNT_FULL && !pop) begin
            // Dropped event; flag set wins over a same-cycle report
            ovf_next = 1'b1; // R5
         end else begin
            mem_next[wr_idx_reg] = push_data;
            wr_idx_next = wr_idx_reg + KQ_IDX_ONE;
            count_next = count_next + KQ_CNT_ONE;
         end
      end
      alert_n_next = alert_n_reg;
      if (push) begin
         alert_n_next = 1'b0;
      end else if (!cfg_s2_reg && count_next == KQ_CNT_ZERO) begin
         alert_n_next = 1'b1; // R11
      end else if (cfg_s2_reg && (pop || ovf_report)) begin
         alert_n_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < KQ_DEPTH; i++) begin
            mem_reg[i] <= 8'h00;
         end
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
         count_reg <= KQ_CNT_ZERO;
         ovf_reg <= 1'b0;
         alert_n_reg <= 1'b1;
      end else begin
         mem_reg <= mem_next;
         wr_idx_reg <= wr_idx_next;
         rd_idx_reg <= rd_idx_next;
         count_reg <= count_next;
         ovf_reg <= ovf_next;
         alert_n_reg <= alert_n_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-wire slave
   kq_state_t state_reg, state_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] tx_reg, tx_next;
   logic [7:0] ptr_reg, ptr_next;
   logic first_reg, first_next;
   logic oe_n_reg, oe_n_next;
   logic load;
   logic [7:0] rd_value;

   // Byte read from the current pointer
   always_comb begin
      if (ptr_reg != KQ_QUEUE_ADDR) begin
         rd_value = KQ_UNMAPPED_DATA;
      end else if (ovf_reg) begin
         rd_value = KQ_CODE_OVERFLOW; // R5
      end else if (count_reg == KQ_CNT_ZERO) begin
         rd_value = KQ_CODE_EMPTY; // R4
      end else begin
         rd_value = head_code;
      end
   end

   assign pop = load && ptr_reg == KQ_QUEUE_ADDR && !ovf_reg && count_reg != KQ_CNT_ZERO; // R9 R12
   assign ovf_report = load && ptr_reg == KQ_QUEUE_ADDR && ovf_reg;

   always_comb begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      ptr_next = ptr_reg;
      first_next = first_reg;
      oe_n_next = oe_n_reg;
      load = 1'b0;
      if (bus_start) begin
         state_next = KQ_ADDR;
         bit_cnt_next = KQ_BIT_CNT_ZERO;
         oe_n_next = 1'b1;
      end else if (bus_stop) begin
         state_next = KQ_IDLE;
         oe_n_next = 1'b1;
      end else begin
         case (state_reg)
            KQ_ADDR, KQ_WR_BYTE: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s2_reg};
                  bit_cnt_next = bit_cnt_reg + KQ_BIT_CNT_ONE;
               end else if (scl_fall && bit_cnt_reg == KQ_BITS_PER_BYTE) begin
                  bit_cnt_next = KQ_BIT_CNT_ZERO;
                  if (state_reg == KQ_WR_BYTE) begin
                     state_next = KQ_WR_ACK;
                     oe_n_next = 1'b0;
                     if (first_reg) begin
                        ptr_next = shift_reg; // R10
                        first_next = 1'b0;
                     end else begin
                        // Data to unimplemented registers is accepted and dropped
                        ptr_next = kq_next_ptr(ptr_reg);
                     end
                  end else if (shift_reg[7:1] == {KQ_SLAVE_PREFIX, sel_s2_reg}) begin
                     state_next = KQ_ADDR_ACK;
                     oe_n_next = 1'b0;
                  end else begin
                     state_next = KQ_IDLE;
                  end
               end
            end
            KQ_ADDR_ACK: begin
               if (scl_fall) begin
                  if (shift_reg[0]) begin
                     load = 1'b1;
                     tx_next = rd_value;
                     ptr_next = kq_next_ptr(ptr_reg);
                     oe_n_next = rd_value[7];
                     state_next = KQ_RD_BYTE;
                  end else begin
                     first_next = 1'b1;
                     oe_n_next = 1'b1;
                     state_next = KQ_WR_BYTE;
                  end
               end
            end
            KQ_WR_ACK: begin
               if (scl_fall) begin
                  oe_n_next = 1'b1;
                  state_next = KQ_WR_BYTE;
               end
            end
            KQ_RD_BYTE: begin
               if (scl_fall) begin
                  bit_cnt_next = bit_cnt_reg + KQ_BIT_CNT_ONE;
                  tx_next = {tx_reg[6:0], 1'b0};
                  if (bit_cnt_reg == KQ_BITS_PER_BYTE - KQ_BIT_CNT_ONE) begin
                     oe_n_next = 1'b1;
                     bit_cnt_next = KQ_BIT_CNT_ZERO;
                     state_next = KQ_RD_ACK;
                  end else begin
                     oe_n_next = tx_reg[6];
                  end
               end
            end
            KQ_RD_ACK: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s2_reg};
               end else if (scl_fall) begin
                  if (!shift_reg[0]) begin
                     // Master acked, keep streaming from the pointer
                     load = 1'b1;
                     tx_next = rd_value;
                     ptr_next = kq_next_ptr(ptr_reg);
                     oe_n_next = rd_value[7];
                     state_next = KQ_RD_BYTE;
                  end else begin
                     state_next = KQ_IDLE;
                  end
               end
            end
            KQ_IDLE: begin
               oe_n_next = 1'b1;
            end
            default: begin
               state_next = KQ_IDLE;
               oe_n_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= KQ_IDLE;
         bit_cnt_reg <= KQ_BIT_CNT_ZERO;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= KQ_QUEUE_ADDR;
         first_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         ptr_reg <= ptr_next;
         first_reg <= first_next;
         oe_n_reg <= oe_n_next;
      end
   end

   // Open drain: only ever pulls low
   logic sda_out_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sda_out_reg <= 1'b0;
      end else begin
         sda_out_reg <= 1'b0;
      end
   end

   assign sda_out = sda_out_reg;
   assign sda_oe_n = oe_n_reg;
   assign key_alert_n = alert_n_reg;
endmodule

// File: kq_key_event_queue_props.sv
module kq_key_event_queue_props
   import kq_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic scan_clk,
   input wire logic evt_valid,
   input wire logic [5:0] evt_key,
   input wire logic evt_release,
   input wire logic evt_repeat,
   input wire logic evt_ready,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic [2:0] addr_sel,
   input wire logic int_clr_cfg,
   input wire logic key_alert_n
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////
   // Two domains, so every property names its own clock
   AST_READY_DROP: assert property (@(posedge scan_clk) disable iff (!resetn)
      evt_valid && evt_ready |=> !evt_ready) else $error("ready held after take");
   AST_READY_LOW: assert property (@(posedge scan_clk) disable iff (!resetn)
      $fell(evt_ready) |-> ##1 !evt_ready [*2]) else $error("ready back too soon");
   AST_READY_BACK: assert property (@(posedge scan_clk) disable iff (!resetn)
      $fell(evt_ready) |-> ##[1:20] evt_ready) else $error("ready never returned");
   AST_ALERT_SET: assert property (@(posedge scan_clk) disable iff (!resetn)
      evt_valid && evt_ready |-> ##[1:12] !key_alert_n) else $error("alert not raised");
   AST_ALERT_FALL: assert property (@(posedge clk) disable iff (!resetn)
      $fell(key_alert_n) |-> !evt_ready) else $error("alert without taken event");
   // Pops happen only after an SCL fall, so alert release sees SCL low
   AST_ALERT_CLR: assert property (@(posedge clk) disable iff (!resetn)
      $rose(key_alert_n) |-> !scl_in) else $error("alert released off a pop");
   AST_OE_SCL_LOW: assert property (@(posedge clk) disable iff (!resetn)
      $changed(sda_oe_n) |-> !scl_in) else $error("sda changed while scl high");
   AST_SDA_PULL: assert property (@(posedge clk) disable iff (!resetn)
      sda_out == 1'b0) else $error("sda driven high");
endmodule

bind kq_key_event_queue kq_key_event_queue_props i_kq_key_event_queue_props (.clk(clk), .resetn(resetn),
   .scan_clk(scan_clk), .evt_valid(evt_valid), .evt_key(evt_key), .evt_release(evt_release),
   .evt_repeat(evt_repeat), .evt_ready(evt_ready), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .addr_sel(addr_sel), .int_clr_cfg(int_clr_cfg), .key_alert_n(key_alert_n));

// File: kq_host_model.sv
module kq_host_model
   import kq_pkg::*;
(
   input wire logic clk,
   input wire logic sda_line,
   input wire logic [2:0] addr_sel,
   output logic scl,
   output logic sda_host
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quarter bit in core cycles; raise it for a slow master
   int q_cyc = 25;
   logic [7:0] rd_q[$];
   logic nack;
   initial begin
      scl = 1'b1;
      sda_host = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_host = b;
      wt(q_cyc);
      scl = 1'b1;
      wt(q_cyc);
      r = sda_line;
      wt(q_cyc);
      scl = 1'b0;
      wt(q_cyc);
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(a, k);
   endtask
   task automatic start();
      sda_host = 1'b1;
      wt(q_cyc);
      scl = 1'b1;
      wt(q_cyc);
      sda_host = 1'b0;
      wt(q_cyc);
      scl = 1'b0;
      wt(q_cyc);
   endtask
   task automatic stop();
      sda_host = 1'b0;
      wt(q_cyc);
      scl = 1'b1;
      wt(q_cyc);
      sda_host = 1'b1;
      wt(q_cyc);
   endtask
   task automatic set_ptr(input logic [7:0] a);
      logic [7:0] r;
      logic k;
      start();
      xfer({KQ_SLAVE_PREFIX, addr_sel, 1'b0}, 1'b1, r, nack);
      xfer(a, 1'b1, r, k);
      stop();
   endtask
   // Last byte is refused so the device stops fetching
   task automatic read(input int n);
      logic [7:0] r;
      logic k;
      rd_q = {};
      start();
      xfer({KQ_SLAVE_PREFIX, addr_sel, 1'b1}, 1'b1, r, nack);
      for (int i = 0; i < n; i++) begin
         xfer(8'hFF, i == n - 1, r, k);
         rd_q.push_back(r);
      end
      stop();
   endtask
endmodule

// File: kq_key_event_queue_tb.sv
module kq_key_event_queue_tb
   import kq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic scan_clk = 1'b0;
   logic resetn = 1'b0;
   logic evt_valid = 1'b0;
   logic [5:0] evt_key = 6'h00;
   logic evt_release = 1'b0;
   logic evt_repeat = 1'b0;
   logic [2:0] addr_sel = 3'h2;
   logic [2:0] host_sel = 3'h2;
   logic int_clr_cfg = 1'b0;
   logic scl, sda_host, sda_out, sda_oe_n, evt_ready, key_alert_n;
   int fails = 0;
   int check_count = 0;
   // Pull-up: line is low when either side pulls it
   wire sda_line = sda_oe_n ? sda_host : 1'b0;
   ////////////////////////////////////////
   kq_key_event_queue i_kq_key_event_queue (.clk(clk), .resetn(resetn), .scan_clk(scan_clk),
      .evt_valid(evt_valid), .evt_key(evt_key), .evt_release(evt_release), .evt_repeat(evt_repeat),
      .evt_ready(evt_ready), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .addr_sel(addr_sel), .int_clr_cfg(int_clr_cfg), .key_alert_n(key_alert_n));
   kq_host_model i_kq_host_model (.clk(clk), .sda_line(sda_line), .addr_sel(host_sel), .scl(scl),
      .sda_host(sda_host));
   initial forever #12.5 clk = ~clk;
   initial begin
      #7;
      forever #40 scan_clk = ~scan_clk;
   end
   ////////////////////////////////////////
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wait_ready();
      int n = 0;
      while (evt_ready !== 1'b1 && n < 40) begin
         @(negedge scan_clk);
         n++;
      end
      check({7'h00, evt_ready}, 8'h01);
   endtask
   // Held until a falling edge sees ready, so the next rise takes it
   task automatic push(input logic [5:0] k, input logic rel, input logic rpt);
      @(negedge scan_clk);
      evt_valid = 1'b1;
      evt_key = k;
      evt_release = rel;
      evt_repeat = rpt;
      wait_ready();
      @(negedge scan_clk);
      evt_valid = 1'b0;
      wait_ready();
      repeat (4) @(negedge clk);
   endtask
   task automatic read_exp(input logic [7:0] exp[$]);
      i_kq_host_model.read(exp.size());
      foreach (exp[i]) check(i_kq_host_model.rd_q[i], exp[i]);
   endtask
   ////////////////////////////////////////
   task automatic sc_empty();
      i_kq_host_model.set_ptr(8'h00);
      check({7'h00, i_kq_host_model.nack}, 8'h00);
      read_exp({8'h3F, 8'h3F});
      check({7'h00, key_alert_n}, 8'h01);
      check({7'h00, sda_out}, 8'h00);
   endtask
   task automatic sc_order();
      push(6'h05, 1'b0, 1'b0);
      push(6'h05, 1'b1, 1'b0);
      push(6'h14, 1'b0, 1'b0);
      check({7'h00, key_alert_n}, 8'h00);
      read_exp({8'h85, 8'hC5, 8'h14, 8'h3F});
      check({7'h00, key_alert_n}, 8'h01);
   endtask
   task automatic sc_special();
      i_kq_host_model.q_cyc = 50;
      push(6'h3E, 1'b0, 1'b0);
      push(6'h3F, 1'b1, 1'b0);
      push(6'h3E, 1'b1, 1'b0);
      push(6'h03, 1'b0, 1'b1);
      push(6'h09, 1'b1, 1'b1);
      read_exp({8'hBE, 8'hFF, 8'hFE, 8'h7E, 8'h3E});
      read_exp({8'h3F});
      i_kq_host_model.q_cyc = 25;
   endtask
   task automatic sc_overflow();
      logic [7:0] exp[$];
      exp = {8'h7F};
      for (int i = 0; i < 17; i++) push(i[5:0], 1'b0, 1'b0);
      for (int i = 0; i < 16; i++) exp.push_back({i < 15, 1'b0, i[5:0]});
      exp.push_back(8'h3F);
      read_exp(exp);
   endtask
   task automatic sc_alert_cfg();
      push(6'h01, 1'b0, 1'b0);
      push(6'h02, 1'b0, 1'b0);
      read_exp({8'h81});
      check({7'h00, key_alert_n}, 8'h00);
      read_exp({8'h02});
      check({7'h00, key_alert_n}, 8'h01);
      int_clr_cfg = 1'b1;
      push(6'h04, 1'b0, 1'b0);
      push(6'h07, 1'b1, 1'b0);
      read_exp({8'h84});
      check({7'h00, key_alert_n}, 8'h01);
      read_exp({8'h47});
      int_clr_cfg = 1'b0;
   endtask
   task automatic sc_unmapped();
      i_kq_host_model.set_ptr(8'h05);
      read_exp({8'h00});
      host_sel = 3'h6;
      i_kq_host_model.set_ptr(8'h00);
      check({7'h00, i_kq_host_model.nack}, 8'h01);
      host_sel = 3'h2;
      read_exp({8'h00});
      addr_sel = 3'h5;
      host_sel = 3'h5;
      i_kq_host_model.set_ptr(8'h00);
      check({7'h00, i_kq_host_model.nack}, 8'h00);
      read_exp({8'h3F});
   endtask
   // Mid-run reset must empty the queue and park the pointer at the queue
   task automatic sc_reset();
      i_kq_host_model.set_ptr(8'h05);
      push(6'h0A, 1'b0, 1'b0);
      check({7'h00, key_alert_n}, 8'h00);
      resetn = 1'b0;
      repeat (8) @(negedge clk);
      check({6'h00, evt_ready, sda_oe_n}, 8'h01);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      check({7'h00, key_alert_n}, 8'h01);
      read_exp({8'h3F});
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      sc_empty();
      sc_order();
      sc_special();
      sc_overflow();
      sc_alert_cfg();
      sc_unmapped();
      sc_reset();
      end_of_test();
   end
   // Run needs about 1.7 ms; kept under 100k core cycles on a hang
   initial begin
      #2_300_000;
      fails++;
      end_of_test();
   end
endmodule
